// >>> src/vdm_pkg.sv
package vdm_pkg;

    // ==================================================================
    // apb register map
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_THRESH = 12'h004;
    localparam logic [11:0] ADDR_DELAY = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00c;

    // control word fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MEAS_LSB = 4;
    localparam int CTRL_ALDIS_BIT = 8;
    localparam int CTRL_SWBLK_BIT = 9;

    // status word fields
    localparam int ST_COND_LSB = 0;
    localparam int ST_BEH_LSB = 4;
    localparam int ST_START_BIT = 8;
    localparam int ST_ALARM_BIT = 9;
    localparam int ST_BLK_BIT = 10;
    localparam int ST_MASK_LSB = 12;

    // ==================================================================
    // mode, selector and condition codes
    localparam logic [2:0] MODE_ON = 3'h1;
    localparam logic [2:0] MODE_BLOCKED = 3'h2;
    localparam logic [2:0] MODE_TEST = 3'h3;
    localparam logic [2:0] MODE_TEST_BLK = 3'h4;
    localparam logic [2:0] MODE_OFF = 3'h5;
    localparam logic [1:0] MEAS_AMP = 2'h1;
    localparam logic [1:0] MEAS_POW = 2'h2;
    localparam logic ALARM_ENABLED = 1'b0;
    localparam logic [1:0] COND_NORMAL = 2'h0;
    localparam logic [1:0] COND_START = 2'h1;
    localparam logic [1:0] COND_ALARM = 2'h2;
    localparam logic [1:0] COND_BLOCKED = 2'h3;

    // ==================================================================
    // threshold in 0.01 % units, delay in 5 ms steps
    localparam logic [13:0] THR_DEFAULT = 14'h03e8;
    localparam logic [13:0] THR_MIN = 14'h000a;
    localparam logic [13:0] THR_MAX = 14'h2710;
    localparam logic [79:0] RESET_RATIO_PCT = 80'h61;
    localparam logic [18:0] DELAY_DEFAULT = 19'h007d0;
    localparam logic [18:0] DELAY_MAX = 19'h57e40;

    // comparison scales: 1e4, 1e6, 1e8, 1e12
    localparam logic [79:0] SCALE_E4 = 80'h2710;
    localparam logic [79:0] SCALE_E6 = 80'hf4240;
    localparam logic [79:0] SCALE_E8 = 80'h5f5e100;
    localparam logic [79:0] SCALE_E12 = 80'he8d4a51000;

    // spectrum bins
    localparam logic [4:0] FUND_IDX = 5'h01;
    localparam logic [4:0] HARM_FIRST = 5'h02;
    localparam logic [4:0] HARM_LAST = 5'h1f;
    localparam logic [1:0] PHASE_LAST = 2'h2;

    // ==================================================================
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int PROG_CYCLE_US = 5000;
    localparam int STAMP_RES_US = 1000;
    localparam int PROG_CYCLE_CLKS = PROG_CYCLE_US * 1000 / CLK_PERIOD_NS;
    localparam int STAMP_CLKS = STAMP_RES_US * 1000 / CLK_PERIOD_NS;

    // event sources
    localparam logic [1:0] EVT_START = 2'h0;
    localparam logic [1:0] EVT_ALARM = 2'h1;
    localparam logic [1:0] EVT_BLOCKED = 2'h2;
    localparam logic [1:0] EVT_DISPLAY = 2'h3;

    typedef struct packed {
        logic [36:0] harm_sum;
        logic [31:0] fund_sq;
    } vdm_phase_s;

    typedef struct packed {
        logic [1:0] src;
        logic on;
        logic [31:0] stamp_ms;
        logic [2:0] fault_mask;
        logic [2:0][15:0] start_val;
    } vdm_event_s;

endpackage

// >>> src/vdm_spec_acc.sv
`timescale 1ns/1ps
module vdm_spec_acc
    import vdm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic bin_valid,
    input wire logic [4:0] bin_index,
    input wire logic [15:0] bin_mag,
    output vdm_phase_s result_reg,
    output logic done_reg
);

    logic [31:0] sq;
    logic [31:0] fund_acc_reg;
    logic [36:0] sum_acc_reg;

    assign sq = bin_mag * bin_mag;

    // ==================================================================
    // running sum of harmonic powers, fundamental held aside
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fund_acc_reg <= 32'h0;
            sum_acc_reg <= 37'h0;
        end else if (bin_valid) begin
            if (bin_index == FUND_IDX) begin
                fund_acc_reg <= sq;
            end
            if (bin_index == HARM_FIRST) begin
                sum_acc_reg <= 37'(sq);
            end else if (bin_index > HARM_FIRST) begin
                sum_acc_reg <= sum_acc_reg + 37'(sq);
            end
        end
    end

    // the last harmonic closes the spectrum; dc bin 0 is ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= bin_valid && (bin_index == HARM_LAST);
            if (bin_valid && (bin_index == HARM_LAST)) begin
                result_reg.harm_sum <= sum_acc_reg + 37'(sq);
                result_reg.fund_sq <= fund_acc_reg;
            end
        end
    end

endmodule

// >>> src/vdm_voltage_distortion_monitor.sv
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module vdm_voltage_distortion_monitor
    import vdm_pkg::*;
#(
    parameter int PROG_CLKS = PROG_CYCLE_CLKS,
    parameter int MS_CLKS = STAMP_CLKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic spec_valid,
    input wire logic [1:0] spec_phase,
    input wire logic [4:0] spec_index,
    input wire logic [15:0] spec_mag,
    input wire logic block_in,
    input wire logic stage_force_en,
    output logic start_out,
    output logic alarm_out,
    output logic blocked_out,
    output logic [1:0] monitor_condition_code,
    output logic [2:0] node_effective_behaviour,
    output logic evt_valid,
    output vdm_event_s evt
);
    if (PROG_CLKS < 2 || PROG_CLKS > 65535 || MS_CLKS < 2 || MS_CLKS > 65535) begin : g_chk
        $error("divider counts out of range");
    end

    // ==================================================================
    // helpers
    function automatic logic mode_blocks(input logic [2:0] m);
        return (m == MODE_BLOCKED) || (m == MODE_TEST_BLK);
    endfunction
    function automatic logic mode_legal(input logic [2:0] m);
        return (m >= MODE_ON) && (m <= MODE_OFF);
    endfunction
    logic [2:0] node_operating_mode_reg;
    logic [1:0] meas_sel_reg;
    logic alarm_enable_setting_reg, sw_block_reg;
    logic [13:0] distortion_threshold_setting_reg;
    logic [18:0] alarm_delay_setting_reg;
    logic [31:0] prdata_reg, stamp_reg;
    logic [15:0] prog_cnt_reg, ms_cnt_reg;
    logic prog_tick, ms_tick, wr_en, hit;
    vdm_phase_s ph_res [3];
    logic [2:0] ph_done, exceed, below, exceed_reg, below_reg, fault_mask_reg;
    logic eff_block, block_smp_reg, pick_reg, pick_next;
    logic start_reg, start_next, alarm_reg, blocked_reg, evt_valid_reg;
    logic [18:0] delay_cnt_reg, delay_cnt_next;
    logic [2:0][15:0] start_val_reg;
    logic [3:0] pend_reg, chg, lvl, grant;
    logic [1:0] grant_src;
    vdm_event_s evt_reg;

    // ==================================================================
    // apb slave, zero wait states
    assign hit = (paddr == ADDR_CTRL) || (paddr == ADDR_THRESH) ||
                 (paddr == ADDR_DELAY) || (paddr == ADDR_STATUS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_reg;
    assign wr_en = psel && penable && pwrite;

    // read data captured in the setup cycle so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
        end else if (psel && !penable) begin
            prdata_reg <= 32'h0;
            unique case (paddr)
                ADDR_CTRL: begin
                    prdata_reg[CTRL_MODE_LSB +: 3] <= node_operating_mode_reg;
                    prdata_reg[CTRL_MEAS_LSB +: 2] <= meas_sel_reg;
                    prdata_reg[CTRL_ALDIS_BIT] <= alarm_enable_setting_reg;
                    prdata_reg[CTRL_SWBLK_BIT] <= sw_block_reg;
                end
                ADDR_THRESH: prdata_reg[13:0] <= distortion_threshold_setting_reg;
                ADDR_DELAY: prdata_reg[18:0] <= alarm_delay_setting_reg;
                ADDR_STATUS: begin
                    prdata_reg[ST_COND_LSB +: 2] <= monitor_condition_code;
                    prdata_reg[ST_BEH_LSB +: 3] <= node_effective_behaviour;
                    prdata_reg[ST_START_BIT] <= start_reg;
                    prdata_reg[ST_ALARM_BIT] <= alarm_reg;
                    prdata_reg[ST_BLK_BIT] <= blocked_reg;
                    prdata_reg[ST_MASK_LSB +: 3] <= fault_mask_reg;
                end
                default: prdata_reg <= 32'h0;
            endcase
        end
    end

    // static settings: no setting-group path touches mode or selector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            node_operating_mode_reg <= MODE_ON;
            meas_sel_reg <= MEAS_AMP;
            alarm_enable_setting_reg <= ALARM_ENABLED;
            sw_block_reg <= 1'b0;
        end else if (wr_en && (paddr == ADDR_CTRL)) begin
            // illegal codes are dropped so the mode never leaves 1..5
            if (mode_legal(pwdata[CTRL_MODE_LSB +: 3])) begin
                node_operating_mode_reg <= pwdata[CTRL_MODE_LSB +: 3];
            end
            if (pwdata[CTRL_MEAS_LSB +: 2] == MEAS_AMP ||
                pwdata[CTRL_MEAS_LSB +: 2] == MEAS_POW) begin
                meas_sel_reg <= pwdata[CTRL_MEAS_LSB +: 2];
            end
            alarm_enable_setting_reg <= pwdata[CTRL_ALDIS_BIT];
            sw_block_reg <= pwdata[CTRL_SWBLK_BIT];
        end
    end

    // threshold and delay; out-of-range writes keep the old value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            distortion_threshold_setting_reg <= THR_DEFAULT;
            alarm_delay_setting_reg <= DELAY_DEFAULT;
        end else if (wr_en) begin
            if (paddr == ADDR_THRESH && pwdata[31:14] == 18'h0 &&
                pwdata[13:0] >= THR_MIN && pwdata[13:0] <= THR_MAX) begin
                distortion_threshold_setting_reg <= pwdata[13:0];
            end
            if (paddr == ADDR_DELAY && pwdata[31:19] == 13'h0 &&
                pwdata[18:0] <= DELAY_MAX) begin
                alarm_delay_setting_reg <= pwdata[18:0];
            end
        end
    end

    // ==================================================================
    // program-cycle and millisecond enables
    assign prog_tick = (prog_cnt_reg == 16'(PROG_CLKS - 1));
    assign ms_tick = (ms_cnt_reg == 16'(MS_CLKS - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_cnt_reg <= 16'h0;
            ms_cnt_reg <= 16'h0;
            stamp_reg <= 32'h0;
        end else begin
            prog_cnt_reg <= prog_tick ? 16'h0 : prog_cnt_reg + 16'h1;
            ms_cnt_reg <= ms_tick ? 16'h0 : ms_cnt_reg + 16'h1;
            if (ms_tick) begin
                stamp_reg <= stamp_reg + 32'h1;
            end
        end
    end

    // ==================================================================
    // per-phase spectrum accumulation and comparison
    for (genvar i = 0; i < 3; i++) begin : g_ph
        logic [79:0] sum80;
        logic [79:0] f80;
        logic [79:0] thr80;
        logic [79:0] rel80;
        vdm_spec_acc u_acc (
            .pclk(pclk),
            .presetn(presetn),
            .bin_valid(spec_valid && (spec_phase == 2'(i))),
            .bin_index(spec_index),
            .bin_mag(spec_mag),
            .result_reg(ph_res[i]),
            .done_reg(ph_done[i])
        );
        assign sum80 = 80'(ph_res[i].harm_sum);
        assign f80 = 80'(ph_res[i].fund_sq);
        assign thr80 = 80'(distortion_threshold_setting_reg);
        assign rel80 = thr80 * RESET_RATIO_PCT;
        // squared form avoids a divider and square root in amplitude mode
        always_comb begin
            if (meas_sel_reg == MEAS_POW) begin
                exceed[i] = (sum80 * SCALE_E4) > (thr80 * f80);
                below[i] = (sum80 * SCALE_E6) < (rel80 * f80);
            end else begin
                exceed[i] = (sum80 * SCALE_E8) > (thr80 * thr80 * f80);
                below[i] = (sum80 * SCALE_E12) < (rel80 * rel80 * f80);
            end
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                exceed_reg[i] <= 1'b0;
                below_reg[i] <= 1'b1;
            end else if (ph_done[i]) begin
                exceed_reg[i] <= exceed[i];
                below_reg[i] <= below[i];
            end
        end
    end

    // ==================================================================
    // pick-up, start, blocked and alarm timing
    assign eff_block = (node_operating_mode_reg == MODE_TEST && stage_force_en) ?
                       sw_block_reg : block_in;

    always_comb begin
        pick_next = (|exceed_reg) || (pick_reg && !(&below_reg));
        if (alarm_enable_setting_reg != ALARM_ENABLED ||
            node_operating_mode_reg == MODE_OFF) begin
            pick_next = 1'b0;
        end
        start_next = pick_next && !eff_block &&
                     !mode_blocks(node_operating_mode_reg);
        delay_cnt_next = (start_next && start_reg && delay_cnt_reg != DELAY_MAX) ?
                         delay_cnt_reg + 19'h1 : delay_cnt_reg;
        if (!start_next) begin
            delay_cnt_next = 19'h0;
        end
    end

    // everything advances once per program cycle with the sampled block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_smp_reg <= 1'b0;
            pick_reg <= 1'b0;
            start_reg <= 1'b0;
            blocked_reg <= 1'b0;
            alarm_reg <= 1'b0;
            delay_cnt_reg <= 19'h0;
        end else if (prog_tick) begin
            block_smp_reg <= eff_block;
            pick_reg <= pick_next;
            start_reg <= start_next;
            blocked_reg <= pick_next && !start_next;
            delay_cnt_reg <= delay_cnt_next;
            alarm_reg <= start_next && (delay_cnt_next >= alarm_delay_setting_reg);
        end
    end

    // snapshot of faulted phases and the harmonic content of all three phases at pick-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_mask_reg <= 3'h0;
            start_val_reg <= '0;
        end else if (prog_tick && pick_next && !pick_reg) begin
            fault_mask_reg <= exceed_reg;
            for (int k = 0; k < 3; k++) begin
                start_val_reg[k] <= ph_res[k].harm_sum[36:21];
            end
        end
    end

    assign start_out = start_reg;
    assign alarm_out = alarm_reg;
    assign blocked_out = blocked_reg;
    // alarm outranks start; blocked outranks both
    assign monitor_condition_code = blocked_reg ? COND_BLOCKED :
                                    alarm_reg ? COND_ALARM :
                                    start_reg ? COND_START : COND_NORMAL;
    // a sampled block (input, or switch in forced test mode) shows on as blocked and test as test-blocked; off stays off
    assign node_effective_behaviour = !block_smp_reg ? node_operating_mode_reg :
        (node_operating_mode_reg == MODE_ON) ? MODE_BLOCKED :
        (node_operating_mode_reg == MODE_TEST) ? MODE_TEST_BLK : node_operating_mode_reg;

    // ==================================================================
    // event queue: one pending bit per source, lowest source first
    assign lvl = {blocked_reg, blocked_reg, alarm_reg, start_reg};
    assign chg = prog_tick ?
                 {pick_next && !start_next && !blocked_reg,
                  (pick_next && !start_next) != blocked_reg,
                  (start_next && (delay_cnt_next >= alarm_delay_setting_reg)) != alarm_reg,
                  start_next != start_reg} : 4'h0;
    assign grant = pend_reg & (~pend_reg + 4'h1);
    // the lowest pending source is granted this cycle and owns the event port the next
    assign grant_src = grant[1] ? EVT_ALARM : grant[2] ? EVT_BLOCKED :
                       grant[3] ? EVT_DISPLAY : EVT_START;

    // a new change in the grant cycle keeps its pending bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_reg <= 4'h0;
        end else begin
            pend_reg <= (pend_reg & ~grant) | chg;
        end
    end

    // every event carries the pick-up snapshot and faulted phases
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_valid_reg <= 1'b0;
            evt_reg <= '0;
        end else begin
            evt_valid_reg <= |pend_reg;
            if (|pend_reg) begin
                evt_reg.src <= grant_src;
                evt_reg.on <= |(grant & lvl);
                evt_reg.stamp_ms <= stamp_reg;
                evt_reg.fault_mask <= fault_mask_reg;
                evt_reg.start_val <= start_val_reg;
            end
        end
    end

    assign evt_valid = evt_valid_reg;
    assign evt = evt_reg;

    // ==================================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_mode_legal;
        mode_legal(node_operating_mode_reg);
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("mode left 1..5");
    property p_start_excl;
        start_reg |-> !blocked_reg;
    endproperty
    a_start_excl: assert property (p_start_excl) else $error("start with blocked");
    property p_start_on_tick;
        $rose(start_reg) |-> $past(prog_tick) && !$past(eff_block);
    endproperty
    a_start_on_tick: assert property (p_start_on_tick) else $error("start off-tick");
    property p_block_drops;
        prog_tick && start_reg && eff_block |=> !start_reg && !alarm_reg;
    endproperty
    a_block_drops: assert property (p_block_drops) else $error("block kept start");
    property p_alarm_delay;
        $rose(alarm_reg) |-> start_reg && delay_cnt_reg >= alarm_delay_setting_reg;
    endproperty
    a_alarm_delay: assert property (p_alarm_delay) else $error("alarm too early");
    property p_alarm_start;
        alarm_reg |-> start_reg;
    endproperty
    a_alarm_start: assert property (p_alarm_start) else $error("alarm without start");
    property p_disabled;
        prog_tick && alarm_enable_setting_reg != ALARM_ENABLED |=> !start_reg && !blocked_reg;
    endproperty
    a_disabled: assert property (p_disabled) else $error("pick-up while disabled");
    property p_cond;
        blocked_reg |-> monitor_condition_code == COND_BLOCKED;
    endproperty
    a_cond: assert property (p_cond) else $error("condition code wrong");
    property p_blk_event;
        $rose(blocked_reg) |-> ##[0:6] (evt_valid && evt.src == EVT_BLOCKED && evt.on);
    endproperty
    a_blk_event: assert property (p_blk_event) else $error("no blocked event");

endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
// ==========
// bench top
module tb;
    import vdm_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
    logic block_in = 0, stage_force_en = 0, pready, pslverr, evt_valid, sv, ea, al, bl, e_l;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [15:0] harm = 0, sm;
    logic [1:0] sp, cc;
    logic [4:0] si;
    logic [2:0] nb;
    vdm_event_s evt;
    int fail_count = 0, compares = 0, n;
    always #50 pclk = ~pclk;
    vdm_spec_src u_src (.pclk(pclk), .presetn(presetn), .go(go), .harm(harm), .spec_valid(sv),
        .spec_phase(sp), .spec_index(si), .spec_mag(sm));
    vdm_voltage_distortion_monitor #(.PROG_CLKS(20), .MS_CLKS(10)) u_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .spec_valid(sv),
        .spec_phase(sp), .spec_index(si), .spec_mag(sm), .block_in(block_in),
        .stage_force_en(stage_force_en), .start_out(ea), .alarm_out(al), .blocked_out(bl),
        .monitor_condition_code(cc), .node_effective_behaviour(nb), .evt_valid(evt_valid),
        .evt(evt));
    task automatic end_sim();
        if (fail_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen high; a hang counts as a mismatch
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        if (n >= 50) begin
            fail_count++;
            end_sim();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0, e_l);
        chk(r, exp);
        chk({31'h0, e_l}, {31'h0, err});
    endtask
    // outputs packed as start alarm blocked cond[1:0] behaviour[2:0], sampled mid-cycle
    task automatic outs(input int ticks, input logic [7:0] exp);
        repeat (ticks * 20) @(posedge pclk);
        @(negedge pclk);
        chk({24'h0, ea, al, bl, cc, nb}, {24'h0, exp});
        @(posedge pclk);
    endtask
    task automatic spec(input logic [15:0] h);
        harm <= h;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (100) @(posedge pclk);
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_CTRL, 32'h11, 1'b0);
        rd(ADDR_THRESH, 32'h3e8, 1'b0);
        rd(ADDR_DELAY, 32'h7d0, 1'b0);
        rd(ADDR_STATUS, 32'h10, 1'b0);
        rd(12'h010, 32'h0, 1'b1);
        // start comes mid-spectrum, so six cycles keep the first check ahead of the alarm
        apb(1'b1, ADDR_DELAY, 32'h6, e_l);
        apb(1'b1, ADDR_DELAY, 32'h57e41, e_l);
        rd(ADDR_DELAY, 32'h6, 1'b0);
        spec(16'h00c8);
        outs(1, 8'h89);
        outs(3, 8'hd1);
        spec(16'h0062);
        outs(1, 8'hd1);
        spec(16'h0060);
        outs(1, 8'h01);
        block_in <= 1'b1;
        spec(16'h00c8);
        outs(1, 8'h3a);
        block_in <= 1'b0;
        outs(1, 8'h89);
        block_in <= 1'b1;
        n = 0;
        // looked at mid-cycle so the one-cycle event is seen while it stands
        while (!(evt_valid === 1'b1 && evt.src === EVT_DISPLAY) && n < 60) begin
            @(negedge pclk);
            n++;
        end
        chk(n < 60, 1);
        chk({28'h0, evt.on, evt.fault_mask}, 32'h9);
        outs(1, 8'h3a);
        block_in <= 1'b0;
        stage_force_en <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h213, e_l);
        outs(1, 8'h3c);
        apb(1'b1, ADDR_CTRL, 32'h15, e_l);
        outs(1, 8'h05);
        apb(1'b1, ADDR_CTRL, 32'h111, e_l);
        outs(1, 8'h01);
        end_sim();
    end
endmodule

// >>> tb/vdm_spec_src.sv
`timescale 1ns/1ps
// ==========
// spectrum source model
module vdm_spec_src
    import vdm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic [15:0] harm,
    output logic spec_valid,
    output logic [1:0] spec_phase,
    output logic [4:0] spec_index,
    output logic [15:0] spec_mag
);
    logic [6:0] cnt_reg;
    logic tog_reg;
    // bins 1..31 of phases 0..2 in order, one per cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 7'h00;
            tog_reg <= 1'b0;
        end else begin
            tog_reg <= ~tog_reg;
            if (cnt_reg == 7'h5d) cnt_reg <= 7'h00;
            else if (cnt_reg != 7'h00 || go) cnt_reg <= cnt_reg + 7'h01;
        end
    end
    // only phase 0 carries a harmonic; the idle magnitude toggles so no stale value looks valid
    assign spec_valid = cnt_reg != 7'h00;
    assign spec_phase = 2'((cnt_reg - 7'h01) / 7'h1f);
    assign spec_index = 5'((cnt_reg - 7'h01) % 7'h1f + 7'h01);
    assign spec_mag = !spec_valid ? (16'h5a5a ^ {16{tog_reg}}) : spec_index == 5'h01 ? 16'h03e8 :
        (spec_index == 5'h02 && spec_phase == 2'h0) ? harm : 16'h0000;
endmodule
